// ### rtl/ea_disp_ext.v
// sign extension of a short or long displacement field
`timescale 1ns/1ps
module ea_disp_ext (
  // raw field and its width selects
  input wire [31:0] raw_i,
  input wire byte_sel_i,
  input wire long_sel_i,
  // extended result
  output reg [31:0] ext_o
);
  // long passes, word and byte are twos complement extended
  always @* begin
    if (long_sel_i) begin
      ext_o = raw_i;
    end else if (byte_sel_i) begin
      ext_o = {{24{raw_i[7]}}, raw_i[7:0]};
    end else begin
      ext_o = {{16{raw_i[15]}}, raw_i[15:0]};
    end
  end
endmodule

// ### rtl/ea_gen_map.vh
// constants for the effective address generator: mode codes, sizes and field widths
`ifndef EA_GEN_MAP_VH
`define EA_GEN_MAP_VH
// addressing mode codes, eighteen in all
`define MODE_DATA_DIRECT 5'h00
`define MODE_ADDR_DIRECT 5'h01
`define MODE_ADDR_IND 5'h02
`define MODE_ADDR_POSTINC 5'h03
`define MODE_ADDR_PREDEC 5'h04
`define MODE_ADDR_DISP 5'h05
`define MODE_ADDR_IDX_SHORT 5'h06
`define MODE_ADDR_IDX_BASE 5'h07
`define MODE_ADDR_MEM_POST 5'h08
`define MODE_ADDR_MEM_PRE 5'h09
`define MODE_PC_DISP 5'h0a
`define MODE_PC_IDX_SHORT 5'h0b
`define MODE_PC_IDX_BASE 5'h0c
`define MODE_PC_MEM_POST 5'h0d
`define MODE_PC_MEM_PRE 5'h0e
`define MODE_ABS_SHORT 5'h0f
`define MODE_ABS_LONG 5'h10
`define MODE_IMMEDIATE 5'h11
// operand size codes
`define SIZE_BYTE 3'h0
`define SIZE_WORD 3'h1
`define SIZE_LONG 3'h2
`define SIZE_QUAD 3'h3
`define SIZE_BCD_PACKED 3'h4
`define SIZE_BCD_UNPACKED 3'h5
`define SIZE_BITFIELD 3'h6
// field widths
`define ADDR_W_FULL 32
`define ADDR_W_REDUCED 24
`define FC_W 3
`define BF_MAX_LEN 6'h20
`endif

// ### rtl/ea_index_scale.v
// index register size select and scale
`timescale 1ns/1ps
module ea_index_scale (
  // index value and controls
  input wire [31:0] idx_i,
  input wire idx_long_i,
  input wire [1:0] scale_i,
  // scaled index
  output reg [31:0] scaled_o
);
  reg [31:0] sized;
  // word index is sign extended before scaling; overflow wraps like the adder
  always @* begin
    sized = idx_long_i ? idx_i : {{16{idx_i[15]}}, idx_i[15:0]};
    scaled_o = sized << scale_i;
  end
endmodule

// ### rtl/effective_address_generator.v
// effective address generator with memory indirection and bus error continuation
`timescale 1ns/1ps
`include "ea_gen_map.vh"
module effective_address_generator #(
  parameter REDUCED = 0
) (
  // clock and reset
  input wire clock_i,
  input wire nrst_i,
  // request from the decoder
  input wire start_i,
  input wire [4:0] mode_i,
  input wire [2:0] size_i,
  input wire [5:0] bf_len_i,
  input wire [2:0] fc_i,
  input wire [31:0] addr_reg_i,
  input wire [31:0] data_reg_i,
  input wire [31:0] idx_addr_reg_i,
  input wire [31:0] idx_data_reg_i,
  input wire idx_from_addr_i,
  input wire idx_long_i,
  input wire [1:0] scale_i,
  input wire [31:0] pc_i,
  input wire [31:0] base_disp_i,
  input wire base_long_i,
  input wire [31:0] outer_disp_i,
  input wire outer_en_i,
  input wire outer_long_i,
  input wire [31:0] ext_word_i,
  input wire [1:0] imm_size_i,
  // memory bus side
  input wire bus_ack_i,
  input wire bus_err_i,
  input wire [31:0] bus_data_i,
  // handler return
  input wire resume_i,
  input wire rerun_i,
  // results
  output reg busy_o,
  output reg done_o,
  output reg [31:0] ea_o,
  output reg [31:0] operand_o,
  output reg is_operand_o,
  output reg [31:0] addr_reg_new_o,
  output reg addr_reg_we_o,
  output reg bad_mode_o,
  output reg bus_req_o,
  output reg [31:0] bus_addr_o,
  output reg [2:0] bus_fc_o,
  output reg fault_o
);
  // one-hot states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_FETCH = 5'h02;
  localparam [4:0] ST_FINAL = 5'h04;
  localparam [4:0] ST_SUSP = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;
  reg [4:0] state;
  reg [4:0] next_state;
  // latched request fields, held across a fault so continuation needs no decoder
  reg [4:0] mode; // decides the register write at the finish
  reg [31:0] inter_addr; // bracketed address for the indirect read
  reg [31:0] post_add; // amount added after the indirect read
  reg [31:0] addr_mask;
  // extended displacement values
  wire [31:0] short_ext;
  wire [31:0] word_ext;
  wire [31:0] base_ext;
  wire [31:0] outer_ext;
  wire [31:0] scaled_idx;
  wire [31:0] outer_term;
  wire [31:0] idx_src;
  reg [31:0] step;
  reg [31:0] calc_ea;
  reg [31:0] calc_inter;
  reg [31:0] calc_post;
  reg [31:0] calc_imm;
  reg calc_mem;
  reg calc_is_op;
  reg calc_bad;
  reg [31:0] base_sel;
  reg [31:0] size_bytes;
  // index source picked from either register file
  assign idx_src = idx_from_addr_i ? idx_addr_reg_i : idx_data_reg_i;
  // short displacement in the extension word
  ea_disp_ext u_short (
    .raw_i(ext_word_i),
    .byte_sel_i(1'b1),
    .long_sel_i(1'b0),
    .ext_o(short_ext)
  );
  // word displacement in the extension word
  ea_disp_ext u_word (
    .raw_i(ext_word_i),
    .byte_sel_i(1'b0),
    .long_sel_i(1'b0),
    .ext_o(word_ext)
  );
  // base displacement, word or long
  ea_disp_ext u_base (
    .raw_i(base_disp_i),
    .byte_sel_i(1'b0),
    .long_sel_i(base_long_i),
    .ext_o(base_ext)
  );
  // outer displacement, word or long
  ea_disp_ext u_outer (
    .raw_i(outer_disp_i),
    .byte_sel_i(1'b0),
    .long_sel_i(outer_long_i),
    .ext_o(outer_ext)
  );
  // scaled index
  ea_index_scale u_idx (
    .idx_i(idx_src),
    .idx_long_i(idx_long_i),
    .scale_i(scale_i),
    .scaled_o(scaled_idx)
  );
  // optional outer term is zero when absent
  assign outer_term = outer_en_i ? outer_ext : 32'h0000_0000;
  // address width, reduced variant drops the top byte
  always @* begin
    addr_mask = REDUCED ? 32'h00ff_ffff : 32'hffff_ffff;
  end
  // byte step for postincrement and predecrement, from operand size
  always @* begin
    case (size_i)
      `SIZE_BYTE: size_bytes = 32'h0000_0001;
      `SIZE_WORD: size_bytes = 32'h0000_0002;
      `SIZE_LONG: size_bytes = 32'h0000_0004;
      `SIZE_QUAD: size_bytes = 32'h0000_0008;
      `SIZE_BCD_PACKED: size_bytes = 32'h0000_0001;
      `SIZE_BCD_UNPACKED: size_bytes = 32'h0000_0001;
      // a bit field steps by a long word
      default: size_bytes = 32'h0000_0004;
    endcase
    step = size_bytes;
  end
  // immediate width select
  always @* begin
    case (imm_size_i)
      2'h0: calc_imm = {24'h00_0000, ext_word_i[7:0]};
      2'h1: calc_imm = {16'h0000, ext_word_i[15:0]};
      default: calc_imm = ext_word_i;
    endcase
  end
  // address arithmetic for every mode
  always @* begin
    calc_ea = 32'h0000_0000;
    calc_inter = 32'h0000_0000;
    calc_post = 32'h0000_0000;
    calc_mem = 1'b0;
    calc_is_op = 1'b0;
    calc_bad = 1'b0;
    // pc modes share the register mode datapath with pc as base
    base_sel = (mode_i >= `MODE_PC_DISP) ? pc_i : addr_reg_i;
    case (mode_i)
      // register direct modes hand back the register itself
      `MODE_DATA_DIRECT: begin
        calc_is_op = 1'b1;
        calc_ea = data_reg_i;
      end
      `MODE_ADDR_DIRECT: begin
        calc_is_op = 1'b1;
        calc_ea = addr_reg_i;
      end
      // indirect forms; predecrement steps before the access
      `MODE_ADDR_IND: calc_ea = addr_reg_i;
      `MODE_ADDR_POSTINC: calc_ea = addr_reg_i;
      `MODE_ADDR_PREDEC: calc_ea = addr_reg_i - step;
      // displacement and index forms, shared by the pc modes
      `MODE_ADDR_DISP, `MODE_PC_DISP: calc_ea = base_sel + word_ext;
      `MODE_ADDR_IDX_SHORT, `MODE_PC_IDX_SHORT: begin
        calc_ea = base_sel + short_ext + scaled_idx;
      end
      `MODE_ADDR_IDX_BASE, `MODE_PC_IDX_BASE: begin
        calc_ea = base_sel + base_ext + scaled_idx;
      end
      // postindexed: the index waits until after the indirect read
      `MODE_ADDR_MEM_POST, `MODE_PC_MEM_POST: begin
        calc_mem = 1'b1;
        calc_inter = base_sel + base_ext;
        calc_post = scaled_idx + outer_term;
      end
      // preindexed: the index goes into the bracketed address
      `MODE_ADDR_MEM_PRE, `MODE_PC_MEM_PRE: begin
        calc_mem = 1'b1;
        calc_inter = base_sel + base_ext + scaled_idx;
        calc_post = outer_term;
      end
      // absolute and immediate forms come from the extension word
      `MODE_ABS_SHORT: calc_ea = {{16{ext_word_i[15]}}, ext_word_i[15:0]};
      `MODE_ABS_LONG: calc_ea = ext_word_i;
      `MODE_IMMEDIATE: begin
        calc_is_op = 1'b1;
        calc_ea = calc_imm;
      end
      // codes past the last mode are refused
      default: calc_bad = 1'b1;
    endcase
    // a bit field longer than a long word or of zero length is refused
    if (size_i == `SIZE_BITFIELD && (bf_len_i == 6'h00 || bf_len_i > `BF_MAX_LEN)) begin
      calc_bad = 1'b1;
    end
  end
  // next state
  always @* begin
    next_state = state;
    case (state)
      // a refused request leaves the machine idle
      ST_IDLE: begin
        if (start_i && !calc_bad) begin
          next_state = calc_mem ? ST_FETCH : ST_DONE;
        end
      end
      ST_FETCH: begin
        // error wins over acknowledge in the same cycle
        if (bus_err_i) begin
          next_state = ST_SUSP;
        end else if (bus_ack_i) begin
          next_state = ST_FINAL;
        end
      end
      ST_FINAL: next_state = ST_DONE;
      // hold until the handler returns; rerun repeats the read
      ST_SUSP: begin
        if (resume_i) begin
          next_state = rerun_i ? ST_FETCH : ST_FINAL;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      // an illegal state code drops back to idle
      default: next_state = ST_IDLE;
    endcase
  end
  // state register and datapath latches
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // every output and latch clears to a constant
      state <= ST_IDLE;
      mode <= 5'h00;
      inter_addr <= 32'h0000_0000;
      post_add <= 32'h0000_0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      ea_o <= 32'h0000_0000;
      operand_o <= 32'h0000_0000;
      is_operand_o <= 1'b0;
      addr_reg_new_o <= 32'h0000_0000;
      addr_reg_we_o <= 1'b0;
      bad_mode_o <= 1'b0;
      bus_req_o <= 1'b0;
      bus_addr_o <= 32'h0000_0000;
      bus_fc_o <= 3'h0;
      fault_o <= 1'b0;
    end else begin
      // pulses fall back unless a branch below raises them
      state <= next_state;
      done_o <= 1'b0;
      addr_reg_we_o <= 1'b0;
      bad_mode_o <= 1'b0;
      case (state)
        // take a request; a refused one only pulses the bad flag
        ST_IDLE: begin
          if (start_i) begin
            mode <= mode_i;
            bad_mode_o <= calc_bad;
            if (!calc_bad) begin
              busy_o <= 1'b1;
              inter_addr <= calc_inter & addr_mask;
              post_add <= calc_post;
              ea_o <= calc_is_op ? calc_ea : (calc_ea & addr_mask);
              is_operand_o <= calc_is_op;
              operand_o <= calc_is_op ? calc_ea : 32'h0000_0000;
              bus_fc_o <= fc_i;
              // memory-indirect forms start the long-word read at once
              if (calc_mem) begin
                bus_req_o <= 1'b1;
                bus_addr_o <= calc_inter & addr_mask;
              end
              // register update for the stepping modes
              if (mode_i == `MODE_ADDR_POSTINC) begin
                addr_reg_new_o <= addr_reg_i + step;
              end else begin
                addr_reg_new_o <= calc_ea;
              end
            end
          end
        end
        // no retry here; the handler decides whether to rerun
        ST_FETCH: begin
          if (bus_err_i) begin
            bus_req_o <= 1'b0;
            fault_o <= 1'b1;
          end else if (bus_ack_i) begin
            bus_req_o <= 1'b0;
            ea_o <= bus_data_i;
          end
        end
        // outer displacement and postindex go on only after the fetch
        ST_FINAL: begin
          ea_o <= (ea_o + post_add) & addr_mask;
        end
        ST_SUSP: begin
          // latched state is kept so the instruction continues, not restarts
          if (resume_i) begin
            fault_o <= 1'b0;
            if (rerun_i) begin
              bus_req_o <= 1'b1;
              bus_addr_o <= inter_addr;
            end else begin
              ea_o <= bus_data_i;
            end
          end
        end
        // one-cycle finish; the register write rides the same pulse
        ST_DONE: begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          addr_reg_we_o <= (mode == `MODE_ADDR_POSTINC) || (mode == `MODE_ADDR_PREDEC);
        end
        default: busy_o <= 1'b0;
      endcase
    end
  end
endmodule

// ### verif/ea_bus_model.sv
// memory bus responder: answers a long-word read after a set wait
`timescale 1ns/1ps
module ea_bus_model (
  // clock and reset
  input wire clock_i,
  input wire nrst_i,
  // read request and controls
  input wire req_i,
  input wire [31:0] addr_i,
  input wire [3:0] wait_i,
  input wire err_i,
  // answer
  output reg ack_o,
  output reg err_o,
  output reg [31:0] data_o
);
  reg [3:0] cnt; // cycles waited on this request
  // one-cycle answer; data is garbage (inverted) once released
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      cnt <= 4'h0;
      data_o <= 32'h0;
    end else if (ack_o || err_o) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      cnt <= 4'h0;
      data_o <= ~data_o;
    end else if (req_i && cnt == wait_i) begin
      // word content is the address halves swapped, so a wrong address shows
      ack_o <= !err_i;
      err_o <= err_i;
      data_o <= {addr_i[15:0], addr_i[31:16]};
    end else begin
      cnt <= req_i ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ### verif/ea_gen_checker.sv
// port-level assertions for the effective address generator
`timescale 1ns/1ps
module ea_gen_checker (
  // clock, reset and request
  input wire clock_i,
  input wire nrst_i,
  input wire start_i,
  input wire [4:0] mode_i,
  input wire [2:0] size_i,
  input wire [5:0] bf_len_i,
  // bus answer and handler return
  input wire bus_ack_i,
  input wire bus_err_i,
  input wire resume_i,
  input wire rerun_i,
  // results
  input wire busy_o,
  input wire done_o,
  input wire addr_reg_we_o,
  input wire bad_mode_o,
  input wire bus_req_o,
  input wire [31:0] bus_addr_o,
  input wire fault_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // a request counts only while idle
  wire take = start_i && !busy_o;
  // a field of zero or over thirty-two bits is refused
  wire bf_bad = size_i == 3'h6 && (bf_len_i == 6'h00 || bf_len_i > 6'h20);
  wire ok = mode_i <= 5'h11 && !bf_bad;
  // the four memory-indirect forms go out on the bus
  wire mem = mode_i == 5'h08 || mode_i == 5'h09 || mode_i == 5'h0d || mode_i == 5'h0e;
  sequence s_ack;
    bus_req_o && bus_ack_i && !bus_err_i;
  endsequence
  sequence s_err;
    bus_req_o && bus_err_i;
  endsequence
  a_take_busy: assert property (take && ok |=> busy_o)
    else $error("legal request not taken");
  a_reg_done: assert property (take && ok && !mem |-> ##2 done_o)
    else $error("register mode late");
  a_bad_refused: assert property (take && !ok |=> !busy_o ##[0:1] bad_mode_o)
    else $error("bad request not refused");
  a_mem_fetch: assert property (take && ok && mem |=> bus_req_o)
    else $error("no indirect fetch");
  a_req_hold: assert property (bus_req_o && !bus_ack_i && !bus_err_i |=> bus_req_o
    && $stable(bus_addr_o))
    else $error("fetch dropped early");
  a_ack_done: assert property (s_ack |-> ##3 done_o)
    else $error("finish after fetch late");
  a_err_fault: assert property (s_err |=> fault_o && !bus_req_o)
    else $error("bus error not suspended");
  a_fault_hold: assert property (fault_o && !resume_i |=> fault_o)
    else $error("suspend left early");
  a_rerun_req: assert property (fault_o && resume_i && rerun_i |-> ##[1:2] bus_req_o)
    else $error("faulted cycle not rerun");
  a_we_done: assert property (addr_reg_we_o |-> done_o)
    else $error("register update apart from done");
endmodule
bind effective_address_generator ea_gen_checker chk (.clock_i, .nrst_i, .start_i, .mode_i,
  .size_i, .bf_len_i, .bus_ack_i, .bus_err_i, .resume_i, .rerun_i, .busy_o, .done_o,
  .addr_reg_we_o, .bad_mode_o, .bus_req_o, .bus_addr_o, .fault_o);

// ### verif/effective_address_generator_tb_top.sv
// self-checking bench for the effective address generator
`timescale 1ns/1ps
`include "ea_gen_map.vh"
module effective_address_generator_tb_top;
  // one table row: mode, size, ext word, {idx file, long, scale}, base disp, results
  typedef struct packed {
    logic [4:0] m;
    logic [2:0] s;
    logic [31:0] x;
    logic [3:0] ix;
    logic [31:0] bd;
    logic [31:0] ea;
    logic [31:0] nw;
  } row_t;
  logic clock_i = 0, nrst_i = 0, start_i = 0, resume_i = 0, rerun_i = 0, err_i = 0;
  logic idx_from_addr_i = 0, idx_long_i = 0, base_long_i = 0, outer_en_i = 1, outer_long_i = 0;
  logic [4:0] mode_i = 0;
  logic [2:0] size_i = 0, fc_i = 3'h5;
  logic [5:0] bf_len_i = 6'h20;
  logic [1:0] scale_i = 0, imm_size_i = 0;
  logic [3:0] wait_i = 0;
  logic [31:0] ext_word_i = 0, base_disp_i = 0, outer_disp_i = 32'h100;
  logic [31:0] addr_reg_i = 32'h1000, data_reg_i = 32'h55, pc_i = 32'h2000;
  logic [31:0] idx_addr_reg_i = 32'h10, idx_data_reg_i = 32'h1fffe;
  wire busy_o, done_o, is_operand_o, addr_reg_we_o, bad_mode_o, bus_req_o, fault_o;
  wire bus_ack_i, bus_err_i;
  wire [2:0] bus_fc_o;
  wire [31:0] ea_o, operand_o, addr_reg_new_o, bus_addr_o, bus_data_i;
  int fail_count = 0, checks = 0, cyc = 0;
  logic op_row, step_row; // row hands back an operand / steps its register
  row_t rows [0:23] = '{
    '{5'h08, 3'h0, 32'h0, 4'h0, 32'h20, 32'h102000fe, 32'h0},
    '{5'h09, 3'h0, 32'h0, 4'h0, 32'h20, 32'h101e0100, 32'h0},
    '{5'h0d, 3'h0, 32'h0, 4'h0, 32'h20, 32'h202000fe, 32'h0},
    '{5'h0e, 3'h0, 32'h0, 4'h0, 32'h20, 32'h201e0100, 32'h0},
    '{5'h00, 3'h2, 32'h0, 4'h0, 32'h0, 32'h55, 32'h0},
    '{5'h01, 3'h2, 32'h0, 4'h0, 32'h0, 32'h1000, 32'h0},
    '{5'h02, 3'h2, 32'h0, 4'h0, 32'h0, 32'h1000, 32'h0},
    '{5'h03, 3'h2, 32'h0, 4'h0, 32'h0, 32'h1000, 32'h1004},
    '{5'h04, 3'h1, 32'h0, 4'h0, 32'h0, 32'hffe, 32'hffe},
    '{5'h04, 3'h3, 32'h0, 4'h0, 32'h0, 32'hff8, 32'hff8},
    '{5'h03, 3'h4, 32'h0, 4'h0, 32'h0, 32'h1000, 32'h1001},
    '{5'h04, 3'h5, 32'h0, 4'h0, 32'h0, 32'hfff, 32'hfff},
    '{5'h03, 3'h6, 32'h0, 4'h0, 32'h0, 32'h1000, 32'h1004},
    '{5'h05, 3'h2, 32'h8000, 4'h0, 32'h0, 32'hffff9000, 32'h0},
    '{5'h06, 3'h2, 32'hff00f0, 4'h2, 32'h0, 32'hfe8, 32'h0},
    '{5'h07, 3'h2, 32'h0, 4'hb, 32'h8000, 32'hffff9080, 32'h0},
    '{5'h07, 3'h2, 32'h0, 4'h4, 32'h100000, 32'h120ffe, 32'h0},
    '{5'h0a, 3'h2, 32'h10, 4'h0, 32'h0, 32'h2010, 32'h0},
    '{5'h0b, 3'h2, 32'h4, 4'h9, 32'h0, 32'h2024, 32'h0},
    '{5'h0c, 3'h2, 32'h0, 4'h0, 32'h100, 32'h20fe, 32'h0},
    '{5'h0f, 3'h2, 32'h8000, 4'h0, 32'h0, 32'hffff8000, 32'h0},
    '{5'h10, 3'h2, 32'h80000000, 4'h0, 32'h0, 32'h80000000, 32'h0},
    '{5'h11, 3'h0, 32'h123456ab, 4'h0, 32'h0, 32'hab, 32'h0},
    '{5'h11, 3'h1, 32'h123456ab, 4'h0, 32'h0, 32'h56ab, 32'h0}
  };
  effective_address_generator dut (.*);
  ea_bus_model mem (.clock_i, .nrst_i, .req_i(bus_req_o), .addr_i(bus_addr_o), .wait_i,
    .err_i, .ack_o(bus_ack_i), .err_o(bus_err_i), .data_o(bus_data_i));
  // 50 ns clock
  initial forever #25 clock_i = ~clock_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // present one request for a single cycle, return just after the take edge
  task automatic launch(input row_t r);
    @(posedge clock_i);
    mode_i <= r.m;
    size_i <= r.s;
    imm_size_i <= r.s[1:0];
    ext_word_i <= r.x;
    {idx_from_addr_i, idx_long_i, scale_i} <= r.ix;
    base_disp_i <= r.bd;
    base_long_i <= |r.bd[31:16];
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    #1;
  endtask
  // bounded wait for the finish pulse
  task automatic go(input row_t r);
    launch(r);
    repeat (40) if (done_o !== 1'b1) begin @(posedge clock_i); #1; end
  endtask
  task automatic bad(input logic [4:0] m, input logic [5:0] l);
    logic b, z;
    @(posedge clock_i);
    mode_i <= m;
    size_i <= 3'h6;
    bf_len_i <= l;
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    b = 0;
    z = 0;
    repeat (3) begin #1; b = b | bad_mode_o; z = z | busy_o; @(posedge clock_i); end
    chk({31'h0, b}, 32'h1);
    chk({31'h0, z}, 32'h0);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clock_i);
    #1;
    chk({25'h0, busy_o, done_o, bus_req_o, fault_o, bad_mode_o, is_operand_o, addr_reg_we_o},
      32'h0);
    chk(ea_o | operand_o | addr_reg_new_o | bus_addr_o | {29'h0, bus_fc_o}, 32'h0);
    @(posedge clock_i);
    nrst_i <= 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      wait_i <= 4'(i % 3);
      go(rows[i]);
      chk({31'h0, done_o}, 32'h1);
      chk(ea_o, rows[i].ea);
      if (rows[i].m == 5'h03 || rows[i].m == 5'h04) chk(addr_reg_new_o, rows[i].nw);
      op_row = rows[i].m inside {5'h00, 5'h01, 5'h11};
      step_row = rows[i].m inside {5'h03, 5'h04};
      chk({30'h0, is_operand_o, addr_reg_we_o}, {30'h0, op_row, step_row});
      chk(operand_o, op_row ? rows[i].ea : 32'h0);
    end
    $display("table test done");
    bad(5'h12, 6'h20);
    bad(5'h1f, 6'h20);
    bad(5'h02, 6'h00);
    bad(5'h02, 6'h21);
    bf_len_i <= 6'h01;
    go('{5'h02, 3'h6, 32'h0, 4'h0, 32'h0, 32'h1000, 32'h0});
    chk(ea_o, 32'h1000);
    $display("refusal test done");
    // fetch faults, a start while busy is ignored, then the handler reruns
    @(posedge clock_i);
    err_i <= 1'b1;
    fc_i <= 3'h2;
    outer_long_i <= 1'b1;
    outer_disp_i <= 32'h10000;
    wait_i <= 4'h2;
    launch(rows[0]);
    @(posedge clock_i);
    mode_i <= 5'h01;
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    #1;
    chk({29'h0, bus_fc_o}, 32'h2);
    repeat (20) if (fault_o !== 1'b1) begin @(posedge clock_i); #1; end
    chk({31'h0, fault_o}, 32'h1);
    @(posedge clock_i);
    err_i <= 1'b0;
    resume_i <= 1'b1;
    rerun_i <= 1'b1;
    @(posedge clock_i);
    resume_i <= 1'b0;
    #1;
    repeat (40) if (done_o !== 1'b1) begin @(posedge clock_i); #1; end
    chk(ea_o, 32'h1020fffe);
    // second fault continues with the word left on the bus, no rerun
    @(posedge clock_i);
    err_i <= 1'b1;
    launch(rows[0]);
    repeat (20) if (fault_o !== 1'b1) begin @(posedge clock_i); #1; end
    chk({31'h0, fault_o}, 32'h1);
    @(posedge clock_i);
    err_i <= 1'b0;
    resume_i <= 1'b1;
    rerun_i <= 1'b0;
    @(posedge clock_i);
    resume_i <= 1'b0;
    #1;
    repeat (40) if (done_o !== 1'b1) begin @(posedge clock_i); #1; end
    chk(ea_o, 32'hefe0fffd);
    $display("bus error test done");
    // reset in the middle of a fetch clears the block, which then takes a request
    @(posedge clock_i);
    wait_i <= 4'h9;
    launch(rows[1]);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk({25'h0, busy_o, done_o, bus_req_o, fault_o, bad_mode_o, is_operand_o, addr_reg_we_o},
      32'h0);
    chk(ea_o | operand_o | addr_reg_new_o | bus_addr_o | {29'h0, bus_fc_o}, 32'h0);
    @(posedge clock_i);
    nrst_i <= 1'b1;
    go(rows[13]);
    chk(ea_o, rows[13].ea);
    $display("mid-run reset test done");
    close_out;
  end
endmodule
